// *** rtl/angle_sensor_config_regs.sv ***
// Configuration and control register bank of the rotation sensor
`include "angle_sensor_defs.svh"
`default_nettype none
module angle_sensor_config_regs #(
    parameter int NCOEF = 13
) (
    input  wire logic                         clock,
    input  wire logic                         sys_rst,
    // Register access from the two-wire bus engine, same clock
    input  wire logic [7:0]                   regAddr,
    input  wire logic [15:0]                  regWrData,
    input  wire logic                         regWrEn,
    input  wire logic                         regRdEn,
    output logic [15:0]                       regRdData,
    output logic                              regRdValid,
    input  wire logic                         sessionStart,
    input  wire logic                         stopSeen,
    input  wire logic [7:0]                   cmdByte,
    input  wire logic                         cmdValid,
    output logic                              windowOpen,
    output logic                              rwCheckEnable,
    output logic                              busAllowed,
    // Core status
    input  wire logic                         tuningActive,
    input  wire logic [3:0]                   livePowerMode,
    input  wire logic                         touch0,
    input  wire logic                         deepSleepActive,
    input  wire logic [4:0]                   eventRaw,
    input  wire logic                         encTimerExpired,
    input  wire logic [1:0]                   encLevel,
    input  wire logic [2:0]                   encState,
    input  wire logic                         stationary,
    input  wire logic                         coasting,
    input  wire logic                         dirRaw,
    input  wire logic                         zeroDone,
    // Controls to the core
    output angle_sensor_pkg::power_mode_t     powerMode,
    output logic                              deepSleepAllowed,
    output logic                              wakeRequest,
    output logic                              eventMode,
    output logic                              streamMode,
    output logic                              hallRetune,
    output logic                              softResetPulse,
    output logic                              tuneStartPulse,
    output logic [4:0]                        eventEnabled,
    output angle_sensor_pkg::encoder_drive_t  encoderDrive,
    output logic                              rotationInterfaceEnable,
    output logic                              hallSensorEnable,
    output logic                              coastingInterfaceEnable,
    output logic                              discardMissed,
    output logic                              forcePreciseRate,
    output logic                              directionOut,
    output logic                              zeroRequest,
    output angle_sensor_pkg::zero_mode_t      zeroMode,
    output logic [NCOEF-1:0][15:0]            coeffOut
);
    import angle_sensor_pkg::*;

    localparam logic [7:0] COEF_ADDR [13] = '{
        `A_FILT0, `A_FILT1, `A_GAIN0, `A_GAIN1, `A_BIAS0, `A_BIAS1,
        `A_COASTFILT, `A_LIM0, `A_LIM1, `A_TUNE,
        `A_TOUCH0, `A_TOUCH1, `A_TOUCH2
    };
    localparam logic [15:0] COEF_MASK [13] = '{
        `MASK_FULL, `MASK_FULL, `MASK_GAIN, `MASK_GAIN, `MASK_FULL,
        `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_BYTE, `MASK_BYTE,
        `MASK_FULL, `MASK_FULL, `MASK_FULL
    };

    logic [15:0]      sysQ;
    logic [15:0]      busQ;
    logic [15:0]      evMaskQ;
    logic [15:0]      encQ;
    logic [15:0]      rotQ;
    logic [15:0]      coefQ [NCOEF];
    logic [NCOEF-1:0] coefHit;
    logic             resetFlagQ;
    logic             windowQ;
    logic             softRstQ;
    logic             tuneQ;
    logic [15:0]      rdD;
    logic [15:0]      rdQ;
    logic             rdValidQ;
    logic             wrSys;
    logic             autoPower;

    assign wrSys = regWrEn && regAddr == `A_SYS;

    // Plain read-write registers; reserved bits never store
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sysQ    <= `RESET_VALUE;
            busQ    <= `RESET_VALUE;
            evMaskQ <= `RESET_VALUE;
            encQ    <= `RESET_VALUE;
        end else if (regWrEn) begin
            unique case (regAddr)
                `A_SYS:    sysQ    <= regWrData & `SYS_MASK;
                `A_BUS:    busQ    <= regWrData & `BUS_MASK;
                `A_EVMASK: evMaskQ <= regWrData & `EV_MASK;
                `A_ENC:    encQ    <= regWrData & `ENC_WMASK;
                default: begin
                end
            endcase
        end
    end

    // Zero-now stays set until the core reports completion or a write clears it; a new write
    // in the completion cycle wins so the request is not lost
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rotQ <= `RESET_VALUE;
        end else if (regWrEn && regAddr == `A_ROT) begin
            rotQ <= regWrData & `ROT_MASK;
            if (!regWrData[`ROT_ZERO] && zeroDone) begin
                rotQ[`ROT_ZERO] <= 1'b0;
            end
        end else if (zeroDone) begin
            rotQ[`ROT_ZERO] <= 1'b0;
        end
    end

    // Coefficient pairs are stored whole; each byte is used on its own.
    // One process drives the packed hit and output vectors, since
    // per-element continuous assigns would give them many drivers.
    always_comb begin
        for (int i = 0; i < NCOEF; i++) begin
            coefHit[i]  = regAddr == COEF_ADDR[i];
            coeffOut[i] = coefQ[i];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NCOEF; gi++) begin : g_coef
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    coefQ[gi] <= `RESET_VALUE;
                end else if (regWrEn && coefHit[gi]) begin
                    coefQ[gi] <= regWrData & COEF_MASK[gi];
                end
            end
        end
    endgenerate

    // Write-one triggers never store; they pulse for one cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            softRstQ <= 1'b0;
            tuneQ    <= 1'b0;
        end else begin
            softRstQ <= wrSys && regWrData[`SYS_SOFTRST];
            tuneQ    <= wrSys && regWrData[`SYS_TUNE];
        end
    end
    assign softResetPulse = softRstQ;
    assign tuneStartPulse = tuneQ;

    // Reset-occurred flag; a soft reset sets it again and beats the ack
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            resetFlagQ <= 1'b1;
        end else if (softRstQ) begin
            resetFlagQ <= 1'b1;
        end else if (wrSys && regWrData[`SYS_ACK]) begin
            resetFlagQ <= 1'b0;
        end
    end

    // Communication window; open wins if start and end coincide
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            windowQ <= 1'b0;
        end else if (sessionStart) begin
            windowQ <= 1'b1;
        end else if (busQ[`BUS_KEEPOPEN]) begin
            if (cmdValid && cmdByte == `END_CMD) begin
                windowQ <= 1'b0;
            end
        end else if (stopSeen) begin
            windowQ <= 1'b0;
        end
    end
    assign windowOpen    = windowQ;
    assign rwCheckEnable = !busQ[`BUS_NOCHECK];
    assign busAllowed    = !tuningActive || sysQ[`SYS_TALK];

    // Power selection decode; unlisted codes flag as bad
    always_comb begin
        unique case (sysQ[`SYS_PWR_LO +: 5])
            5'h00:   powerMode = PM_PRECISE;
            5'h01:   powerMode = PM_NORMAL;
            5'h02:   powerMode = PM_LOW;
            5'h04:   powerMode = PM_DEEP;
            5'h08:   powerMode = PM_HALT;
            5'h09:   powerMode = PM_AUTO;
            default: powerMode = PM_BAD;
        endcase
    end
    assign autoPower = powerMode == PM_AUTO;

    assign deepSleepAllowed = sysQ[`SYS_DEEP] && autoPower;
    // Only channel 0 touch leaves deep sleep
    assign wakeRequest = deepSleepActive && touch0;
    assign eventMode   = sysQ[`SYS_EVENT];
    assign streamMode  = sysQ[`SYS_STREAM];
    assign hallRetune  = sysQ[`SYS_RETUNE];
    assign eventEnabled = eventRaw & evMaskQ[4:0];

    // Code 3 is undefined; the driver stays off rather than guess
    always_comb begin
        unique case (encQ[1:0])
            2'h1:    encoderDrive = DRV_OPEN_DRAIN;
            2'h2:    encoderDrive = DRV_PUSH_PULL;
            default: encoderDrive = DRV_OFF;
        endcase
    end

    assign rotationInterfaceEnable = rotQ[`ROT_UI];
    assign hallSensorEnable        = rotQ[`ROT_HALL];
    assign coastingInterfaceEnable = rotQ[`ROT_COAST];
    assign discardMissed           = rotQ[`ROT_DISCARD];
    assign forcePreciseRate = rotQ[`ROT_FORCE] && autoPower
                              && coasting;
    assign directionOut = dirRaw ^ rotQ[`ROT_REVERSE];
    assign zeroRequest  = rotQ[`ROT_ZERO];
    assign zeroMode = zero_mode_t'(rotQ[`ROT_AZ_LO +: 2]);

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rdD = 16'h0000;
        unique case (regAddr)
            `A_STATUS:
                rdD = {10'h000, livePowerMode, resetFlagQ,
                       tuningActive};
            `A_COAST_FLAGS:
                rdD = {14'h0000, stationary, coasting};
            `A_SYS:    rdD = sysQ;
            `A_BUS:    rdD = busQ;
            `A_EVMASK: rdD = evMaskQ;
            `A_ENC:
                rdD = {2'h0, encTimerExpired,
                       encLevel,
                       encState,
                       6'h00, encQ[1:0]};
            `A_ROT:    rdD = rotQ;
            default: begin
                for (int i = 0; i < NCOEF; i++) begin
                    if (coefHit[i]) begin
                        rdD = coefQ[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdQ      <= 16'h0000;
            rdValidQ <= 1'b0;
        end else begin
            rdValidQ <= regRdEn;
            if (regRdEn) begin
                rdQ <= rdD;
            end
        end
    end
    assign regRdData  = rdQ;
    assign regRdValid = rdValidQ;
endmodule
`default_nettype wire

// *** rtl/angle_sensor_defs.svh ***
// Register map, field positions and reset values of the configuration bank
// Contract
// - Deep sleep allowed only with bit 14 and automatic power; touch 0 wakes.
// - System bit 13: 0 streaming reports, 1 event-driven reports.
// - Power field bits 8-12: 0,1,2,4,8,9 select precise..automatic modes.
// - System bit 5: 1 allows bus traffic while tuning, 0 forbids it.
// - System bit 4 enables runtime retuning of the Hall channel.
// - Write-one triggers: bit 3 acknowledge, bit 2 reset, bit 1 tune.
// - System bit 0: 0 standalone quadrature, 1 bus streaming.
// - Bus settings bit 1 set disables the read-write consistency check.
// - Bus bit 0 clear: window ends at STOP; set: ends at 0xFF.
// - Mask bits 4..0 enable Hall, proximity, touch, tuning, power events.
// - Encoder bit 13 shows the sequencer timer has expired.
// - Encoder bits 12 and 11 show output levels of encoder 1 and 0.
// - Encoder bits 8-10 show sequencer state, codes 0 to 4.
// - Encoder bits 0-1: 0 off, 1 open-drain, 2 push-pull.
// - Rotation bits 8, 1, 0 enable rotation interface, Hall sensor, coasting.
// - Rotation bit 7 set discards missed intervals while stationary.
// - Rotation bit 6 with automatic power forces precise rate while coasting.
// - Rotation bit 5 inverts the sampled direction.
// - Rotation bit 4 requests zeroing and clears itself when done.
// - Rotation bits 2-3: zeroing off, stationary, continuous, on release.
// - Coasting flags: bit 1 stationary, bit 0 coasting active.
// - Coefficient registers hold two independent unsigned bytes; the gain pair keeps only bits 13-0, limit 1 and tune only the low byte.
// - Status shows a reset-occurred flag, cleared by the acknowledge trigger.
`ifndef ANGLE_SENSOR_DEFS_SVH
`define ANGLE_SENSOR_DEFS_SVH

`define A_STATUS      8'h10
`define A_COAST_FLAGS 8'h14
`define A_SYS         8'h60
`define A_BUS         8'h61
`define A_EVMASK      8'h67
`define A_ENC         8'h69
`define A_ROT         8'h7a
`define A_FILT0       8'h78
`define A_FILT1       8'h79
`define A_GAIN0       8'h80
`define A_GAIN1       8'h81
`define A_BIAS0       8'h82
`define A_BIAS1       8'h83
`define A_COASTFILT   8'h97
`define A_LIM0        8'h98
`define A_LIM1        8'h99
`define A_TUNE        8'ha2
`define A_TOUCH0      8'hb4
`define A_TOUCH1      8'hb5
`define A_TOUCH2      8'hb6

`define SYS_MASK      16'h7f31
`define SYS_DEEP      14
`define SYS_EVENT     13
`define SYS_PWR_LO    8
`define SYS_TALK      5
`define SYS_RETUNE    4
`define SYS_ACK       3
`define SYS_SOFTRST   2
`define SYS_TUNE      1
`define SYS_STREAM    0

`define BUS_MASK      16'h0003
`define BUS_NOCHECK   1
`define BUS_KEEPOPEN  0
`define END_CMD       8'hff

`define EV_MASK       16'h001f
`define ENC_WMASK     16'h0003

`define ROT_MASK      16'h01ff
`define ROT_UI        8
`define ROT_DISCARD   7
`define ROT_FORCE     6
`define ROT_REVERSE   5
`define ROT_ZERO      4
`define ROT_AZ_LO     2
`define ROT_HALL      1
`define ROT_COAST     0

`define MASK_FULL     16'hffff
`define MASK_GAIN     16'h3fff
`define MASK_BYTE     16'h00ff
`define RESET_VALUE   16'h0000

`endif

// *** rtl/angle_sensor_pkg.sv ***
// Types shared by the configuration bank and its users
`default_nettype none
package angle_sensor_pkg;
    typedef enum logic [2:0] {
        PM_PRECISE, PM_NORMAL, PM_LOW, PM_DEEP, PM_HALT, PM_AUTO, PM_BAD
    } power_mode_t;
    typedef enum logic [1:0] {
        DRV_OFF, DRV_OPEN_DRAIN, DRV_PUSH_PULL
    } encoder_drive_t;
    typedef enum logic [1:0] {
        AZ_OFF, AZ_STATIONARY, AZ_CONTINUOUS, AZ_RELEASE
    } zero_mode_t;
endpackage
`default_nettype wire

// *** bench/angle_sensor_config_checker.sv ***
// Assertion checker for the configuration bank ports
`include "angle_sensor_defs.svh"
`default_nettype none
module angle_sensor_config_checker (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrEn,
    input  wire logic        sessionStart,
    input  wire logic        stopSeen,
    input  wire logic [7:0]  cmdByte,
    input  wire logic        cmdValid,
    input  wire logic        windowOpen,
    input  wire logic        rwCheckEnable,
    input  wire logic        softResetPulse,
    input  wire logic        tuneStartPulse,
    input  wire logic        zeroRequest,
    input  wire logic        zeroDone,
    input  wire logic        deepSleepAllowed,
    input  var  angle_sensor_pkg::power_mode_t powerMode
);
    import angle_sensor_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Shadow of the bus settings, so the window checks know the close style
    logic [1:0] busCfg_q;
    wire logic  sysWr  = regWrEn && regAddr == `A_SYS;
    wire logic  softWr = sysWr && regWrData[`SYS_SOFTRST];
    wire logic  tuneWr = sysWr && regWrData[`SYS_TUNE];
    wire logic  zeroWr = regWrEn && regAddr == `A_ROT && regWrData[`ROT_ZERO];
    wire logic  endCmd = cmdValid && cmdByte == `END_CMD;
    wire logic  keep   = busCfg_q[0];
    always_ff @(posedge clock) begin
        if (sys_rst)
            busCfg_q <= 2'h0;
        else if (regWrEn && regAddr == `A_BUS)
            busCfg_q <= regWrData[1:0];
    end
    property p_soft; softResetPulse == $past(softWr); endproperty
    a_soft: assert property (p_soft) else $error("soft reset pulse");
    property p_tune; tuneStartPulse == $past(tuneWr); endproperty
    a_tune: assert property (p_tune) else $error("tune pulse");
    property p_open; sessionStart |=> windowOpen; endproperty
    a_open: assert property (p_open) else $error("window not open");
    // A start in the same cycle keeps the window open, so it is excluded
    property p_stop;
        windowOpen && stopSeen && !keep && !sessionStart |=> !windowOpen;
    endproperty
    a_stop: assert property (p_stop) else $error("stop kept open");
    property p_cmd;
        windowOpen && endCmd && keep && !sessionStart |=> !windowOpen;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command kept open");
    property p_keep; windowOpen && keep && !endCmd |=> windowOpen; endproperty
    a_keep: assert property (p_keep) else $error("closed too soon");
    property p_rwc; rwCheckEnable != busCfg_q[1]; endproperty
    a_rwc: assert property (p_rwc) else $error("check enable wrong");
    property p_deep; deepSleepAllowed |-> powerMode == PM_AUTO; endproperty
    a_deep: assert property (p_deep) else $error("deep sleep wrong");
    property p_zset; zeroWr |=> zeroRequest; endproperty
    a_zset: assert property (p_zset) else $error("zero not raised");
    property p_zclr; zeroRequest && zeroDone && !zeroWr |=> !zeroRequest;
    endproperty
    a_zclr: assert property (p_zclr) else $error("zero stuck high");
    c_soft: cover property (softResetPulse);
    c_close: cover property (windowOpen ##1 !windowOpen);
    c_zero: cover property (zeroRequest ##1 !zeroRequest);
endmodule
`default_nettype wire

// *** bench/bus_host_model.sv ***
// Behavioural model of the bus engine that issues word accesses
`default_nettype none
module bus_host_model (
    output logic             regWrEn,
    output logic             regRdEn,
    output logic             sessionStart,
    output logic             stopSeen,
    output logic             cmdValid,
    output logic [7:0]       regAddr,
    output logic [7:0]       cmdByte,
    output logic [15:0]      regWrData,
    input  wire logic        clock,
    input  wire logic [15:0] regRdData,
    input  wire logic        regRdValid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {regWrEn, regRdEn, sessionStart, stopSeen, cmdValid} = 5'h00;
        regAddr = 8'h00;
        cmdByte = 8'h00;
        regWrData = 16'h0000;
    end
    // Released lines show the inverse so stale values cannot pass
    task automatic writeWord(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'h1;
        @(posedge clock);
        #1;
        regWrEn = 1'h0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    task automatic readWord(input logic [7:0] a, output logic [15:0] d);
        int n;
        @(posedge clock);
        #1;
        regAddr = a;
        regRdEn = 1'h1;
        @(posedge clock);
        #1;
        regRdEn = 1'h0;
        for (n = 0; n < 4 && regRdValid !== 1'h1; n++) begin
            @(posedge clock);
            #1;
        end
        d = (regRdValid === 1'h1) ? regRdData : 16'hxxxx;
        regAddr = ~a;
    endtask
    task automatic linkEvent(input logic s, p, c, input logic [7:0] b);
        @(posedge clock);
        #1;
        sessionStart = s;
        stopSeen = p;
        cmdValid = c;
        cmdByte = b;
        @(posedge clock);
        #1;
        {sessionStart, stopSeen, cmdValid} = 3'h0;
        cmdByte = ~b;
    endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the configuration register bank
`include "angle_sensor_defs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import angle_sensor_pkg::*;
    logic clock, sys_rst, regWrEn, regRdEn, regRdValid, sessionStart;
    logic stopSeen, cmdValid, windowOpen, rwCheckEnable, busAllowed;
    logic tuningActive, touch0, deepSleepActive, encTimerExpired;
    logic stationary, coasting, dirRaw, zeroDone, deepSleepAllowed;
    logic wakeRequest, eventMode, streamMode, hallRetune, softResetPulse;
    logic tuneStartPulse, rotationInterfaceEnable, hallSensorEnable;
    logic coastingInterfaceEnable, discardMissed, forcePreciseRate;
    logic directionOut, zeroRequest;
    logic [7:0]        regAddr, cmdByte;
    logic [15:0]       regWrData, regRdData, rd;
    logic [3:0]        livePowerMode;
    logic [4:0]        eventRaw, eventEnabled;
    logic [2:0]        encState;
    logic [1:0]        encLevel;
    logic [12:0][15:0] coeffOut;
    power_mode_t       powerMode;
    encoder_drive_t    encoderDrive;
    zero_mode_t        zeroMode;
    int                nMismatch = 0, samplesChecked = 0, cycles = 0;
    localparam logic [7:0] ADDRS [19] = '{`A_SYS, `A_BUS, `A_EVMASK, `A_ENC,
        `A_ROT, `A_FILT0, `A_FILT1, `A_GAIN0, `A_GAIN1, `A_BIAS0, `A_BIAS1,
        `A_COASTFILT, `A_LIM0, `A_LIM1, `A_TUNE, `A_TOUCH0, `A_TOUCH1,
        `A_TOUCH2, 8'h70};
    localparam logic [15:0] MASKS [19] = '{`SYS_MASK, `BUS_MASK, `EV_MASK,
        `ENC_WMASK, `ROT_MASK, `MASK_FULL, `MASK_FULL, `MASK_GAIN, `MASK_GAIN,
        `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_FULL, `MASK_BYTE, `MASK_BYTE,
        `MASK_FULL, `MASK_FULL, `MASK_FULL, 16'h0000};
    // Bit 4 stays clear in the patterns: it is the self-clearing zero request
    localparam logic [15:0] PATS [3] = '{16'h0000, 16'hffef, 16'h5aa5};
    localparam logic [4:0] PCODE [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08,
        5'h09, 5'h03};
    localparam power_mode_t PEXP [7] = '{PM_PRECISE, PM_NORMAL, PM_LOW,
        PM_DEEP, PM_HALT, PM_AUTO, PM_BAD};
    localparam encoder_drive_t DEXP [4] = '{DRV_OFF, DRV_OPEN_DRAIN,
        DRV_PUSH_PULL, DRV_OFF};
    angle_sensor_config_regs dut_u (.*);
    bus_host_model host_u (.*);
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    task automatic completeRun();
        if (nMismatch == 0 && samplesChecked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            nMismatch++;
            completeRun();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
        host_u.readWord(a, rd);
        chk(rd, exp);
    endtask
    task automatic winChk(input logic s, p, c, input logic [7:0] b,
                          input logic e);
        host_u.linkEvent(s, p, c, b);
        chk(16'(windowOpen), 16'(e));
    endtask
    initial begin
        sys_rst = 1'h1;
        {tuningActive, touch0, deepSleepActive, encTimerExpired} = 4'h0;
        {stationary, coasting, dirRaw, zeroDone} = 4'h0;
        {livePowerMode, eventRaw, encState, encLevel} = 14'h0000;
        repeat (16) @(posedge clock);
        #1;
        sys_rst = 1'h0;
        rdChk(`A_STATUS, 16'h0002);
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 19; i++) begin
                if (p > 0)
                    host_u.writeWord(ADDRS[i], PATS[p]);
                rdChk(ADDRS[i], PATS[p] & MASKS[i]);
            end
        end
        chk(coeffOut[0], 16'h5aa5);
        chk(coeffOut[12], 16'h5aa5);
        for (int i = 0; i < 7; i++) begin
            host_u.writeWord(`A_SYS, {3'h2, PCODE[i], 8'h00});
            chk(16'(powerMode), 16'(PEXP[i]));
            chk(16'(deepSleepAllowed), 16'(i == 5));
        end
        {deepSleepActive, touch0} = 2'h3;
        #1;
        chk(16'(wakeRequest), 16'h0001);
        {tuningActive, touch0} = 2'h2;
        host_u.writeWord(`A_SYS, 16'h2031);
        chk(16'(wakeRequest), 16'h0000);
        rd = 16'({eventMode, hallRetune, streamMode, busAllowed});
        chk(rd, 16'h000f);
        livePowerMode = 4'h9;
        host_u.writeWord(`A_SYS, 16'h0008);
        rdChk(`A_STATUS, 16'h0025);
        rd = 16'({eventMode, hallRetune, streamMode, busAllowed});
        chk(rd, 16'h0000);
        host_u.writeWord(`A_SYS, 16'h0000);
        rdChk(`A_STATUS, 16'h0025);
        host_u.writeWord(`A_SYS, 16'h0006);
        rdChk(`A_STATUS, 16'h0027);
        rdChk(`A_SYS, 16'h0000);
        eventRaw = 5'h1f;
        for (int b = 0; b < 5; b++) begin
            host_u.writeWord(`A_EVMASK, 16'hffe0 | (16'h0001 << b));
            chk(16'(eventEnabled), 16'h0001 << b);
        end
        {encTimerExpired, encLevel, encState} = 6'h34;
        for (int m = 0; m < 4; m++) begin
            host_u.writeWord(`A_ENC, 16'hff00 | 16'(m));
            rdChk(`A_ENC, 16'h3400 | 16'(m));
            chk(16'(encoderDrive), 16'(DEXP[m]));
        end
        host_u.writeWord(`A_BUS, 16'h0000);
        chk(16'(rwCheckEnable), 16'h0001);
        winChk(1'h1, 1'h0, 1'h0, 8'h00, 1'h1);
        winChk(1'h0, 1'h0, 1'h1, `END_CMD, 1'h1);
        winChk(1'h0, 1'h1, 1'h0, 8'h00, 1'h0);
        host_u.writeWord(`A_BUS, 16'h0003);
        chk(16'(rwCheckEnable), 16'h0000);
        winChk(1'h1, 1'h0, 1'h0, 8'h00, 1'h1);
        winChk(1'h0, 1'h1, 1'h0, 8'h00, 1'h1);
        winChk(1'h0, 1'h0, 1'h1, 8'h12, 1'h1);
        winChk(1'h0, 1'h0, 1'h1, `END_CMD, 1'h0);
        host_u.writeWord(`A_SYS, 16'h0900);
        chk(16'(deepSleepAllowed), 16'h0000);
        {coasting, dirRaw} = 2'h3;
        host_u.writeWord(`A_ROT, 16'h01ef);
        rd = 16'({rotationInterfaceEnable, discardMissed, forcePreciseRate,
            directionOut, zeroMode, hallSensorEnable,
            coastingInterfaceEnable});
        chk(rd, 16'h00ef);
        host_u.writeWord(`A_SYS, 16'h0000);
        chk(16'(forcePreciseRate), 16'h0000);
        host_u.writeWord(`A_ROT, 16'h0010);
        chk(16'(zeroRequest), 16'h0001);
        zeroDone = 1'h1;
        @(posedge clock);
        #1;
        zeroDone = 1'h0;
        chk(16'(zeroRequest), 16'h0000);
        rdChk(`A_ROT, 16'h0000);
        stationary = 1'h1;
        rdChk(`A_COAST_FLAGS, 16'h0003);
        // Mid-run reset must bring the bus settings back to their defaults
        sys_rst = 1'h1;
        @(posedge clock);
        #1;
        sys_rst = 1'h0;
        chk(16'(rwCheckEnable), 16'h0001);
        rdChk(`A_BUS, 16'h0000);
        completeRun();
    end
endmodule
bind angle_sensor_config_regs angle_sensor_config_checker checker_u (.*);
`default_nettype wire
